// ---- verilog/pbm_defines.svh ----
`ifndef PBM_DEFINES_SVH
`define PBM_DEFINES_SVH
`define PBM_ADDR_CONTROL 5'h00
`define PBM_ADDR_STATUS 5'h01
`define PBM_ADDR_ID_HIGH 5'h02
`define PBM_ADDR_ID_LOW 5'h03
`define PBM_ADDR_ADVERTISE 5'h04
`define PBM_ADDR_PARTNER 5'h05
`define PBM_ADDR_XCVR_CTRL 5'h19
`define PBM_CTL_RESTART 9
`define PBM_CTL_AN_ENABLE 12
`define PBM_CTL_COL_TEST 7
`define PBM_CTL_KEEP_MASK 16'hFF80
`define PBM_CTL_RESET_VAL 16'h0000
`define PBM_STATUS_FIXED 16'h7849
`define PBM_ST_AN_DONE 5
`define PBM_ST_REMOTE_FAULT 4
`define PBM_ST_LINK 2
`define PBM_ST_JABBER 1
`define PBM_ADV_WMASK 16'hADFF
`define PBM_ADV_RESET_VAL 16'h0001
`define PBM_ADV_FAST_FD 8
`define PBM_ADV_FAST_HD 7
`define PBM_PAR_MASK 16'hEFFF
`define PBM_PAR_ACK 14
`define PBM_XC_PAUSE_RX 13
`define PBM_XC_PAUSE_TX 12
`define PBM_COL_ASSERT_BITS 512
`define PBM_COL_RELEASE_BITS 4
`endif

// ---- verilog/pbm_pkg.sv ----
package pbm_pkg;
  // One management access toward the register bank
  typedef struct packed {
    logic rd;         // Read strobe, one cycle
    logic wr;         // Write strobe, one cycle
    logic [4:0] addr; // Register address
    logic [15:0] wdata; // Write data
  } pbm_req_t;
  // Live line conditions fed from the transceiver core
  typedef struct packed {
    logic link_ok;      // Valid link present
    logic far_fault;    // Far-end fault indication seen
    logic jabber;       // Jabber condition (10 Mb/s)
    logic an_done;      // Negotiation finished
    logic an_started;   // Negotiation has begun
    logic page_valid;   // Received word valid pulse
    logic [15:0] page;  // Received link code word
    logic ack_seen;     // Acknowledge seen in bursts
  } pbm_line_t;
endpackage : pbm_pkg

// ---- verilog/pbm_col_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pbm_defines.svh"
module pbm_col_test
  import pbm_pkg::*;
#(
  parameter int ASSERT_CYC = 1,  // Cycles before collision rises
  parameter int RELEASE_CYC = 1  // Cycles before collision falls
)(
  input wire logic core_clk,  // Core clock
  input wire logic rst,       // Async reset, high
  input wire logic clk_en,    // Freezes state when low
  input wire logic enable,    // Collision test mode
  input wire logic tx_en,     // Transmit enable, synchronous
  output logic col            // Collision echo, registered
);
  // Width fits the longer of the two counts
  localparam int CW = 16;
  logic [CW-1:0] cnt; // Delay counter
  // Echo transmit enable with bounded lag; both delays fit inside the limits
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      col <= 1'b0;
      cnt <= '0;
    end
    else if (clk_en)
    begin
      if (!enable)
      begin
        // Normal operation drops collision at once
        col <= 1'b0;
        cnt <= '0;
      end
      else if (tx_en != col)
      begin
        if (cnt >= CW'(((col ? RELEASE_CYC : ASSERT_CYC)) - 1))
        begin
          col <= tx_en;
          cnt <= '0;
        end
        else
          cnt <= cnt + 1'b1;
      end
      else
        cnt <= '0;
    end
  end
endmodule : pbm_col_test
`default_nettype wire

// ---- verilog/pbm_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pbm_defines.svh"
module pbm_regs
  import pbm_pkg::*;
#(
  parameter logic [23:0] ORG_CODE = 24'h123456, // Arbitrary value
  parameter logic [5:0] MODEL = 6'h2A,          // Arbitrary value
  parameter logic [3:0] REVISION = 4'h3,        // Arbitrary value
  parameter int BIT_RATE_MBPS = 10,             // Line rate for bit times
  parameter int CLK_MHZ = 10                    // Core clock rate
)(
  input wire logic core_clk,        // Core clock, 10 MHz
  input wire logic rst,             // Async reset, high
  input wire logic clk_en,          // Freezes all state when low
  input wire logic soft_rst,        // Software reset pulse
  input wire logic strap_fast_fd,   // Strap, 100 full duplex
  input wire logic strap_fast_hd,   // Strap, 100 half duplex
  input wire pbm_pkg::pbm_req_t req, // Management access
  input wire pbm_pkg::pbm_line_t line, // Line conditions, synchronous
  input wire logic tx_en,           // Transmit enable
  output logic [15:0] rdata,        // Read data, registered
  output logic rvalid,              // Read data valid pulse
  output logic col,                 // Collision output
  output logic [15:0] adv_word,     // Base code word to send
  output logic restart_an,          // Restart request level
  output logic an_enable,           // Negotiation enabled
  output logic [1:0] pause_mode,    // Resolved pause, rx/tx
  output logic preamble_ok          // Suppressed preamble accepted
);
  import pbm_pkg::*;

  // Bit time cycles: both counts round down, floor one
  localparam int COL_ASSERT_CYC_R = (`PBM_COL_ASSERT_BITS * CLK_MHZ) / BIT_RATE_MBPS;
  localparam int COL_ASSERT_CYC = (COL_ASSERT_CYC_R < 1) ? 1 : COL_ASSERT_CYC_R;
  localparam int COL_RELEASE_CYC_R = (`PBM_COL_RELEASE_BITS * CLK_MHZ) / BIT_RATE_MBPS;
  localparam int COL_RELEASE_CYC = (COL_RELEASE_CYC_R < 1) ? 1 : COL_RELEASE_CYC_R;

  logic [15:0] ctl;        // Control word, stored bits only
  logic [15:0] adv;        // Advertisement word
  logic [15:0] partner;    // Received partner word
  logic rfault_lat;        // Remote fault latch
  logic link_lat;          // Link latch, low on failure
  logic jabber_lat;        // Jabber latch
  logic rd_status;         // Status read taken on this edge
  logic [2:0] release_q;   // Per latch: read answered, no event on its edge
  logic fault_ev;          // Any remote fault event this cycle
  logic [15:0] next_rdata; // Read mux result
  logic [1:0] strap_meta;  // Strap pins, first synchroniser stage
  logic [1:0] strap_sync;  // Strap pins, settled: full then half duplex
  logic strap_take;        // Capture straps after reset release

  // Address match used by reads and writes alike
  function automatic logic hit(input pbm_req_t r, input logic [4:0] a);
    hit = (r.addr == a);
  endfunction : hit

  // Straps are pins from outside the clock domain, so they pass two stages
  // before any logic looks at them. The stages have no reset on purpose:
  // they keep sampling while reset is held, so the settled level is ready
  // for the capture on the first edge after release.
  // Limitation: reset must be held for at least two clocks for that to hold.
  always_ff @(posedge core_clk)
  begin
    if (clk_en)
    begin
      // First stage may go metastable; only the second one is read
      strap_meta <= {strap_fast_fd, strap_fast_hd};
      strap_sync <= strap_meta;
    end
  end

  // Straps are caught by the clock after reset release, not in reset
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      strap_take <= 1'b1;
    else if (clk_en)
      strap_take <= soft_rst;
  end

  // Control word: only bits 15:7 are storage
  // Bits 6:0 have no flops at all, so they read zero whatever was written;
  // the restart bit clears itself once negotiation starts or is disabled
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      ctl <= `PBM_CTL_RESET_VAL;
    else if (clk_en)
    begin
      if (soft_rst)
        ctl <= `PBM_CTL_RESET_VAL;
      else if (req.wr && hit(req, `PBM_ADDR_CONTROL))
        ctl <= req.wdata & `PBM_CTL_KEEP_MASK;
      else if (line.an_started || !ctl[`PBM_CTL_AN_ENABLE])
        ctl[`PBM_CTL_RESTART] <= 1'b0;
    end
  end

  // Advertisement word with strapped fast abilities
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      adv <= `PBM_ADV_RESET_VAL;
    else if (clk_en)
    begin
      if (strap_take)
      begin
        adv <= `PBM_ADV_RESET_VAL;
        adv[`PBM_ADV_FAST_FD] <= strap_sync[1];
        adv[`PBM_ADV_FAST_HD] <= strap_sync[0];
      end
      else if (req.wr && hit(req, `PBM_ADDR_ADVERTISE))
        adv <= req.wdata & `PBM_ADV_WMASK;
    end
  end

  // Received word; next pages simply overwrite the base page
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      partner <= 16'h0000;
    else if (clk_en)
    begin
      if (soft_rst)
        partner <= 16'h0000;
      else
      begin
        if (line.page_valid)
          partner <= line.page & `PBM_PAR_MASK;
        partner[`PBM_PAR_ACK] <= line.ack_seen;
      end
    end
  end

  // Status read taken on this edge
  assign rd_status = req.rd && hit(req, `PBM_ADDR_STATUS);

  // Release flags, one per latch: 2 remote fault, 1 link, 0 jabber.
  // The answer is captured on the read edge, so an event on that same edge
  // is not in it; such a lane is not released and waits for the next read.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      release_q <= 3'h0;
    else if (clk_en)
      release_q <= {3{rd_status}} & ~{fault_ev, !line.link_ok, line.jabber};
  end

  assign fault_ev = line.far_fault || partner[13];

  // Latched status bits; a new event beats the release
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rfault_lat <= 1'b0;
      link_lat <= 1'b0;
      jabber_lat <= 1'b0;
    end
    else if (clk_en)
    begin
      if (soft_rst)
      begin
        rfault_lat <= 1'b0;
        link_lat <= 1'b0;
        jabber_lat <= 1'b0;
      end
      else
      begin
        // Set wins over the read release
        // Remote fault: far-end indication or partner's fault bit
        if (fault_ev)
          rfault_lat <= 1'b1;
        else if (release_q[2])
          rfault_lat <= 1'b0;
        // Link: any failure drops it, only a read with good link raises it
        if (!line.link_ok)
          link_lat <= 1'b0;
        else if (release_q[1])
          link_lat <= 1'b1;
        // Jabber: set by the condition, dropped by an answered read
        if (line.jabber)
          jabber_lat <= 1'b1;
        else if (release_q[0])
          jabber_lat <= 1'b0;
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    next_rdata = 16'h0000;
    case (req.addr)
      `PBM_ADDR_CONTROL: next_rdata = ctl;
      `PBM_ADDR_STATUS:
      begin
        next_rdata = `PBM_STATUS_FIXED;
        next_rdata[`PBM_ST_AN_DONE] = line.an_done;
        next_rdata[`PBM_ST_REMOTE_FAULT] = rfault_lat;
        next_rdata[`PBM_ST_LINK] = link_lat;
        next_rdata[`PBM_ST_JABBER] = jabber_lat;
      end
      // Code bit n in the standard numbering sits at ORG_CODE[24-n]; bits 1
      // and 2 are dropped, 3 to 18 fill the high word, 19 to 24 head the low
      `PBM_ADDR_ID_HIGH: next_rdata = ORG_CODE[21:6];
      `PBM_ADDR_ID_LOW: next_rdata = {ORG_CODE[5:0], MODEL, REVISION};
      `PBM_ADDR_ADVERTISE: next_rdata = adv;
      `PBM_ADDR_PARTNER: next_rdata = partner;
      `PBM_ADDR_XCVR_CTRL:
      begin
        next_rdata[`PBM_XC_PAUSE_RX] = pause_mode[1];
        next_rdata[`PBM_XC_PAUSE_TX] = pause_mode[0];
      end
      default: next_rdata = 16'h0000;
    endcase
  end

  // Registered read data, one cycle after the strobe
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      rdata <= 16'h0000;
      rvalid <= 1'b0;
    end
    else if (clk_en)
    begin
      rvalid <= req.rd;
      if (req.rd)
        rdata <= next_rdata;
    end
  end

  // Pause resolution from local and partner pause/asymmetric bits.
  // Both pause bits set: pause in both directions.
  // Local both, partner asymmetric only: local honours received pause only.
  // Local asymmetric only, partner both: local sends pause only.
  // Anything else: no pause; the result is read back at address 19h.
  always_comb
  begin
    pause_mode = 2'b00;
    if (adv[10] && partner[10])
      pause_mode = 2'b11;
    else if (adv[10] && adv[11] && partner[11])
      pause_mode = 2'b10;
    else if (!adv[10] && adv[11] && partner[10] && partner[11])
      pause_mode = 2'b01;
  end

  assign adv_word = adv;
  assign restart_an = ctl[`PBM_CTL_RESTART] && ctl[`PBM_CTL_AN_ENABLE];
  assign an_enable = ctl[`PBM_CTL_AN_ENABLE];
  assign preamble_ok = 1'b1;

  // Collision test echo
  pbm_col_test #(
    .ASSERT_CYC(COL_ASSERT_CYC),
    .RELEASE_CYC(COL_RELEASE_CYC)
  ) u_col (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .enable(ctl[`PBM_CTL_COL_TEST]),
    .tx_en(tx_en),
    .col(col)
  );
endmodule : pbm_regs
`default_nettype wire

// ---- verif/pbm_regs_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module pbm_regs_asserts
  import pbm_pkg::*;
(
  input wire logic core_clk, // Core clock
  input wire logic rst, // Async reset, high
  input wire logic clk_en, // State enable
  input wire logic soft_rst, // Software reset pulse
  input wire pbm_pkg::pbm_req_t req, // Management access
  input wire pbm_pkg::pbm_line_t line, // Line conditions
  input wire logic tx_en, // Transmit enable
  input wire logic [15:0] rdata, // Read data
  input wire logic rvalid, // Read answer pulse
  input wire logic col, // Collision echo
  input wire logic [15:0] adv_word, // Advertised word
  input wire logic restart_an, // Restart level
  input wire logic an_enable, // Negotiation enabled
  input wire logic [1:0] pause_mode, // Pause result
  input wire logic preamble_ok // Preamble flag
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Taken reads, in general and of the status word
  wire logic rd = req.rd && clk_en;
  wire logic rd_st = rd && req.addr == 5'h01;
  // Cycles whose line events the latches really take
  wire logic ev_ok = clk_en && !soft_rst;
  // Negotiation start on a taken cycle with no write that could set restart
  wire logic an_go = line.an_started && clk_en && !req.wr;
  AST_RVALID: assert property (rd |=> rvalid)
    else $error("read not answered");
  AST_CTL_LOW: assert property (rd && req.addr == 5'h00 |=> rdata[6:0] == 7'h00)
    else $error("control low bits set");
  AST_STATUS_FIXED: assert property (rd_st |=> (rdata & 16'hFFC9) == 16'h7849)
    else $error("status fixed bits wrong");
  AST_AN_DONE: assert property (rd_st && line.an_done && $past(line.an_done) |=> rdata[5])
    else $error("negotiation done not shown");
  // Events from an earlier cycle must be visible in the answer
  AST_FAULT_LATCH: assert property (rd_st && $past(line.far_fault && ev_ok) |=> rdata[4])
    else $error("remote fault not latched");
  AST_LINK_LATCH: assert property (rd_st && $past(!line.link_ok && ev_ok) |=> !rdata[2])
    else $error("link loss not latched");
  AST_JABBER_LATCH: assert property (rd_st && $past(line.jabber && ev_ok) |=> rdata[1])
    else $error("jabber not latched");
  AST_COL_FALL: assert property ($fell(tx_en) |-> ##[1:5] !col)
    else $error("collision held too long");
  AST_XC_PAUSE: assert property (rd && req.addr == 5'h19 |=> rdata == {2'b00, $past(pause_mode), 12'h000})
    else $error("pause result not reported");
  AST_ADV_FIXED: assert property (!adv_word[14] && !adv_word[9])
    else $error("advertise fixed bits set");
  AST_RESTART: assert property (restart_an && an_go |=> !restart_an)
    else $error("restart not cleared after start");
  AST_PREAMBLE: assert property (preamble_ok)
    else $error("preamble flag low");
  COV_STATUS_READ: cover property (rd_st ##1 rdata[1]);
  COV_COL_FALL: cover property ($fell(tx_en) ##1 col);
  COV_RESTART: cover property ($fell(restart_an));
endmodule : pbm_regs_asserts
bind pbm_regs pbm_regs_asserts u_chk (.core_clk, .rst, .clk_en, .soft_rst, .req, .line, .tx_en, .rdata,
  .rvalid, .col, .adv_word, .restart_an, .an_enable, .pause_mode, .preamble_ok);
`default_nettype wire

// ---- verif/pbm_mgmt_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pbm_mgmt_model
  import pbm_pkg::*;
(
  input wire logic core_clk, // Core clock
  input wire logic rst, // Async reset, high
  input wire logic go, // Issue one access
  input wire logic wr, // Write when high
  input wire logic [4:0] addr, // Register address
  input wire logic [15:0] wdata, // Write data
  output var pbm_pkg::pbm_req_t req // Strobes toward the bank
);
  // One-cycle strobes; idle qualifiers are scrambled so nothing relies on stale values
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      req <= '0;
    else
    begin
      req.rd <= go && !wr;
      req.wr <= go && wr;
      req.addr <= go ? addr : ~addr;
      req.wdata <= go ? ((addr == 5'h01) ? (wdata & 16'hF87F) : wdata) : ~wdata;
    end
  end
endmodule : pbm_mgmt_model
`default_nettype wire

// ---- verif/tb_pbm_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_pbm_regs;
  import pbm_pkg::*;
  localparam logic [5:0] MODEL = 6'h15; // Arbitrary value
  localparam logic [3:0] REV = 4'h9; // Arbitrary value
  localparam logic [23:0] ORG = 24'h123456; // Arbitrary value
  logic clk_en = 1'b1; // State enable, dropped once
  logic [1:0] pm; // Expected pause result
  logic core_clk = 1'b0, rst = 1'b1, soft_rst = 1'b0, tx_en = 1'b0; // Clock, resets, transmit
  logic go = 1'b0, wr = 1'b0; // Access request to the model
  logic [1:0] strap = 2'b00; // Strap levels, full then half
  logic [4:0] addr = 5'h00; // Access address
  logic [15:0] wdata = 16'h0000; // Access data
  pbm_line_t ln = '0; // Line conditions
  pbm_req_t req; // Strobes from the model
  logic [15:0] rdata, adv_word, r, page; // Outputs and scratch
  logic rvalid, col, restart_an, an_enable, preamble_ok; // Flags
  logic [1:0] pause_mode; // Pause result
  logic [15:0] q_exp[$], q_msk[$]; // Outstanding read notes
  int fails = 0, n_compared = 0, seed = 30, n; // Counters and seed
  always #50 core_clk = ~core_clk;
  pbm_mgmt_model u_mgmt (.core_clk, .rst, .go, .wr, .addr, .wdata, .req);
  pbm_regs #(.ORG_CODE(ORG), .MODEL(MODEL), .REVISION(REV)) uut (.core_clk, .rst, .clk_en, .soft_rst,
    .strap_fast_fd(strap[1]), .strap_fast_hd(strap[0]), .req, .line(ln), .tx_en, .rdata,
    .rvalid, .col, .adv_word, .restart_an, .an_enable, .pause_mode, .preamble_ok);
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // One access; for a read, d is the expected word and m the bits that matter
  task automatic acc(logic w, logic [4:0] a, logic [15:0] d, logic [15:0] m);
    @(posedge core_clk);
    go <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    if (!w)
    begin
      q_exp.push_back(d);
      q_msk.push_back(m);
    end
    @(posedge core_clk);
    go <= 1'b0;
  endtask : acc
  task automatic finish_test;
    // A read still waiting for its answer is a mismatch too
    if (q_exp.size() != 0)
      fails++;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  // Answers are sampled mid-cycle, away from the edge that updates them
  always @(negedge core_clk)
  begin
    if (rvalid === 1'b1)
    begin
      if (q_exp.size() == 0)
        check("unexpected rvalid", 16'h0001, 16'h0000);
      else
      begin
        check("rdata", rdata & q_msk[0], q_exp[0] & q_msk[0]);
        void'(q_exp.pop_front());
        void'(q_msk.pop_front());
      end
    end
  end
  // Watchdog: the sequence needs under a thousand cycles
  initial
  begin
    #2000000;
    fails++;
    finish_test();
  end
  initial
  begin
    strap = 2'($random(seed));
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    r = 16'h0001 | {7'h00, strap, 7'h00};
    acc(1'b0, 5'h00, 16'h0000, 16'hFFFF);
    acc(1'b0, 5'h04, r, 16'hFFFF);
    acc(1'b0, 5'h05, 16'h0000, 16'hFFFF);
    acc(1'b1, 5'h03, 16'hFFFF, 16'h0000);
    acc(1'b1, 5'h07, 16'hFFFF, 16'h0000);
    acc(1'b0, 5'h02, 16'h48D1, 16'hFFFF);
    acc(1'b0, 5'h03, {6'h16, MODEL, REV}, 16'hFFFF);
    acc(1'b0, 5'h07, 16'h0000, 16'hFFFF);
    acc(1'b1, 5'h00, 16'h7F7F, 16'h0000);
    acc(1'b0, 5'h00, 16'h0200, 16'h027F);
    $display("reset values and read-only places done");
    repeat (4)
    begin
      r = 16'($random(seed));
      acc(1'b1, 5'h04, r, 16'h0000);
      acc(1'b0, 5'h04, r & 16'hADFF, 16'hFFFF);
      check("adv_word", adv_word, r & 16'hADFF);
    end
    acc(1'b1, 5'h00, 16'h1200, 16'h0000);
    @(posedge core_clk);
    ln.an_started <= 1'b1;
    repeat (3) @(posedge core_clk);
    ln.an_started <= 1'b0;
    acc(1'b0, 5'h00, 16'h0000, 16'h027F);
    page = 16'($random(seed)) & 16'hDFFF;
    @(posedge core_clk);
    ln.page <= page;
    ln.page_valid <= 1'b1;
    ln.ack_seen <= 1'b1;
    @(posedge core_clk);
    ln.page_valid <= 1'b0;
    acc(1'b0, 5'h05, (page & 16'hAFFF) | 16'h4000, 16'hFFFF);
    acc(1'b0, 5'h19, 16'h0000, 16'hCFFF);
    for (int k = 0; k < 16; k++)
    begin
      // Local asymmetric/pause in k[3:2], partner asymmetric/pause in k[1:0]
      acc(1'b1, 5'h04, {4'h0, 2'(k >> 2), 10'h001}, 16'h0000);
      @(posedge core_clk);
      ln.page <= {4'h0, 2'(k), 10'h000};
      ln.page_valid <= 1'b1;
      @(posedge core_clk);
      ln.page_valid <= 1'b0;
      pm = (k == 14) ? 2'b10 : (k == 11) ? 2'b01 : (k[2] && k[0]) ? 2'b11 : 2'b00;
      acc(1'b0, 5'h19, {2'b00, pm, 12'h000}, 16'hFFFF);
    end
    $display("advertise and partner done");
    acc(1'b0, 5'h01, 16'h7849, 16'hFFC9);
    @(posedge core_clk);
    ln.jabber <= 1'b1;
    ln.far_fault <= 1'b1;
    ln.link_ok <= 1'b1;
    ln.an_done <= 1'b1;
    @(posedge core_clk);
    ln.jabber <= 1'b0;
    ln.far_fault <= 1'b0;
    acc(1'b0, 5'h01, 16'h787B, 16'hFFFF);
    acc(1'b0, 5'h01, 16'h786D, 16'hFFFF);
    @(posedge core_clk);
    ln.link_ok <= 1'b0;
    @(posedge core_clk);
    ln.link_ok <= 1'b1;
    acc(1'b0, 5'h01, 16'h7869, 16'hFFFF);
    acc(1'b0, 5'h01, 16'h786D, 16'hFFFF);
    // A jabber event on the very edge that takes a status read must survive it
    @(posedge core_clk);
    go <= 1'b1;
    wr <= 1'b0;
    addr <= 5'h01;
    q_exp.push_back(16'h786D);
    q_msk.push_back(16'hFFFF);
    @(posedge core_clk);
    go <= 1'b0;
    ln.jabber <= 1'b1;
    @(posedge core_clk);
    ln.jabber <= 1'b0;
    acc(1'b0, 5'h01, 16'h786F, 16'hFFFF);
    acc(1'b0, 5'h01, 16'h786D, 16'hFFFF);
    $display("latched status done");
    acc(1'b1, 5'h00, 16'h0080, 16'h0000);
    @(posedge core_clk);
    tx_en <= 1'b1;
    n = 0;
    while (col !== 1'b1 && n < 600)
    begin
      @(negedge core_clk);
      n++;
    end
    check("col_late", 16'(n > 513), 16'h0000);
    @(posedge core_clk);
    tx_en <= 1'b0;
    repeat (6) @(negedge core_clk);
    check("col", {15'h0000, col}, 16'h0000);
    @(posedge core_clk);
    soft_rst <= 1'b1;
    @(posedge core_clk);
    soft_rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    acc(1'b0, 5'h00, 16'h0000, 16'hFFFF);
    acc(1'b0, 5'h05, 16'h0000, 16'hBFFF);
    acc(1'b0, 5'h04, 16'h0001 | {7'h00, strap, 7'h00}, 16'hFFFF);
    acc(1'b0, 5'h01, 16'h7869, 16'hFFFF);
    // With the enable low a write is lost and the word keeps its value
    repeat (3) @(posedge core_clk);
    clk_en <= 1'b0;
    acc(1'b1, 5'h04, 16'hFFFF, 16'h0000);
    @(posedge core_clk);
    clk_en <= 1'b1;
    acc(1'b0, 5'h04, 16'h0001 | {7'h00, strap, 7'h00}, 16'hFFFF);
    repeat (4) @(posedge core_clk);
    $display("collision and soft reset done");
    finish_test();
  end
endmodule : tb_pbm_regs
`default_nettype wire
